/* File: hdl/process_fault_monitor.v */
// Three-channel process fault monitor with blanking and reaction delays
//
// What this block does
// - Three independent channels, each with own input, mode and timing.
// - Mode 0 never requests a fault shutdown.
// - Modes 1-3 trigger on closed input: any, ready/run, run only.
// - Modes 4-6 trigger on open input: any, ready/run, run only.
// - Response 1 only sets the alarm flag after the reaction delay.
// - Response 2 alarms at once, faults after delay if still triggered.
// - Response 3 requests a fault once the reaction delay elapsed.
// - Reaction delay 0 to 300 s, default 0, timed from trigger.
// - After start, input ignored for start delay of 0 to 600 s.
// - Start blanking only applies in modes 3 and 6.
// - Mode resets to 0, response resets to 3.
// - Channels two and three behave exactly like channel one.
`timescale 1ns/100ps
`include "process_fault_monitor_defines.vh"

module process_fault_monitor #(
  parameter TICK_CYCLES = `TICK_CYCLES,
  parameter TICKS_PER_S = `TICKS_PER_S
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire [2:0] faultIn,
  input  wire       stateReady,
  input  wire       stateRun,
  input  wire       startCmd,
  input  wire       faultReset,
  input  wire       cfgLoad,
  input  wire [2:0] ch1MonitorMode,
  input  wire [1:0] ch1ResponseSelect,
  input  wire [9:0] ch1StartBlankTime,
  input  wire [9:0] ch1ReactionDelay,
  input  wire [2:0] ch2MonitorMode,
  input  wire [1:0] ch2ResponseSelect,
  input  wire [9:0] ch2StartBlankTime,
  input  wire [9:0] ch2ReactionDelay,
  input  wire [2:0] ch3MonitorMode,
  input  wire [1:0] ch3ResponseSelect,
  input  wire [9:0] ch3StartBlankTime,
  input  wire [9:0] ch3ReactionDelay,
  output reg  [2:0] alarmFlag,
  output reg  [2:0] faultRequest,
  output wire       faultShutdown
);

  //--------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------
  function trigCond;
    input [2:0] mode;
    input       closed;
    input       ready;
    input       run;
    begin
      case (mode)
        `MODE_NO_ALWAYS: trigCond = closed;
        `MODE_NO_READY:  trigCond = closed & (ready | run);
        `MODE_NO_RUN:    trigCond = closed & run;
        `MODE_NC_ALWAYS: trigCond = ~closed;
        `MODE_NC_READY:  trigCond = ~closed & (ready | run);
        `MODE_NC_RUN:    trigCond = ~closed & run;
        default:         trigCond = 1'b0;
      endcase
    end
  endfunction

  function isRunOnly;
    input [2:0] mode;
    begin
      isRunOnly = (mode == `MODE_NO_RUN) || (mode == `MODE_NC_RUN);
    end
  endfunction

  function [9:0] clampSec;
    input [9:0] val;
    input [9:0] lim;
    begin
      clampSec = (val > lim) ? lim : val;
    end
  endfunction

  //--------------------------------------------------------------
  // Input synchronisers
  //--------------------------------------------------------------
  reg [2:0] inMeta_q;
  reg [2:0] inSync_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inMeta_q <= 3'h0;
      inSync_q <= 3'h0;
    end else begin
      inMeta_q <= faultIn;
      inSync_q <= inMeta_q;
    end
  end

  //--------------------------------------------------------------
  // Millisecond and second ticks
  //--------------------------------------------------------------
  reg  [16:0] tickCnt_q;
  reg  [9:0]  msCnt_q;
  wire        msTick  = (tickCnt_q == TICK_CYCLES - 1);
  wire        secTick = msTick && (msCnt_q == TICKS_PER_S - 1);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= 17'h0;
      msCnt_q   <= 10'h0;
    end else if (msTick) begin
      tickCnt_q <= 17'h0;
      msCnt_q   <= secTick ? 10'h0 : msCnt_q + 10'h1;
    end else begin
      tickCnt_q <= tickCnt_q + 17'h1;
    end
  end

  //--------------------------------------------------------------
  // Settings, loaded on cfgLoad
  //--------------------------------------------------------------
  reg [2:0] mode_q  [0:2];
  reg [1:0] resp_q  [0:2];
  reg [9:0] blank_q [0:2];
  reg [9:0] react_q [0:2];

  wire [2:0] modeIn  [0:2];
  wire [1:0] respIn  [0:2];
  wire [9:0] blankIn [0:2];
  wire [9:0] reactIn [0:2];
  assign modeIn[0]  = ch1MonitorMode;
  assign modeIn[1]  = ch2MonitorMode;
  assign modeIn[2]  = ch3MonitorMode;
  assign respIn[0]  = ch1ResponseSelect;
  assign respIn[1]  = ch2ResponseSelect;
  assign respIn[2]  = ch3ResponseSelect;
  assign blankIn[0] = ch1StartBlankTime;
  assign blankIn[1] = ch2StartBlankTime;
  assign blankIn[2] = ch3StartBlankTime;
  assign reactIn[0] = ch1ReactionDelay;
  assign reactIn[1] = ch2ReactionDelay;
  assign reactIn[2] = ch3ReactionDelay;

  //--------------------------------------------------------------
  // Per-channel monitor
  //--------------------------------------------------------------
  reg  [9:0] blankCnt_q [0:2];
  reg  [9:0] delayCnt_q [0:2];
  reg  [2:0] delayDone_q;
  reg  [2:0] runOnly;
  reg  [2:0] blanked;
  reg  [2:0] condMet;
  reg  [2:0] trig;
  reg  [2:0] alarmSet;
  reg  [2:0] faultSet;
  reg  [2:0] faultClr;
  integer    c;
  integer    j;
  integer    k;
  integer    n;
  integer    p;

  //--------------------------------------------------------------
  // Settings register
  //--------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (k = 0; k < 3; k = k + 1) begin
        mode_q[k]  <= `MODE_RESET;
        resp_q[k]  <= `RESP_RESET;
        blank_q[k] <= `DELAY_RESET;
        react_q[k] <= `DELAY_RESET;
      end
    end else if (cfgLoad) begin
      for (k = 0; k < 3; k = k + 1) begin
        mode_q[k]  <= (modeIn[k] > `MODE_NC_RUN) ? `MODE_OFF : modeIn[k];
        resp_q[k]  <= (respIn[k] == 2'h0) ? `RESP_FAULT : respIn[k];
        blank_q[k] <= clampSec(blankIn[k], `START_MAX_S);
        react_q[k] <= clampSec(reactIn[k], `REACT_MAX_S);
      end
    end
  end

  //--------------------------------------------------------------
  // Trigger decode
  //--------------------------------------------------------------
  always @* begin
    runOnly = 3'h0;
    blanked = 3'h0;
    condMet = 3'h0;
    trig    = 3'h0;
    for (c = 0; c < 3; c = c + 1) begin
      runOnly[c] = isRunOnly(mode_q[c]);
      blanked[c] = runOnly[c] & (blankCnt_q[c] != 10'h0);
      condMet[c] = trigCond(mode_q[c], inSync_q[c],
                            stateReady, stateRun);
      trig[c]    = condMet[c] & ~blanked[c];
    end
  end

  //--------------------------------------------------------------
  // Start blanking counters
  //--------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (n = 0; n < 3; n = n + 1)
        blankCnt_q[n] <= `DELAY_RESET;
    end else begin
      for (n = 0; n < 3; n = n + 1) begin
        if (startCmd)
          blankCnt_q[n] <= blank_q[n];
        else if (secTick && blankCnt_q[n] != 10'h0)
          blankCnt_q[n] <= blankCnt_q[n] - 10'h1;
      end
    end
  end

  //--------------------------------------------------------------
  // Reaction delay timers
  //--------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (p = 0; p < 3; p = p + 1)
        delayCnt_q[p] <= `DELAY_RESET;
      delayDone_q <= 3'h0;
    end else begin
      for (p = 0; p < 3; p = p + 1) begin
        if (!trig[p]) begin
          // Trigger gone: restart from zero
          delayCnt_q[p]  <= 10'h0;
          delayDone_q[p] <= 1'b0;
        end else if (!delayDone_q[p]) begin
          if (delayCnt_q[p] >= react_q[p])
            delayDone_q[p] <= 1'b1;
          else if (secTick)
            delayCnt_q[p] <= delayCnt_q[p] + 10'h1;
        end
      end
    end
  end

  //--------------------------------------------------------------
  // Response decode
  //--------------------------------------------------------------
  always @* begin
    alarmSet = 3'h0;
    faultSet = 3'h0;
    faultClr = 3'h0;
    for (j = 0; j < 3; j = j + 1) begin
      case (resp_q[j])
        `RESP_ALARM: begin
          alarmSet[j] = trig[j] & delayDone_q[j];
          faultSet[j] = 1'b0;
        end
        `RESP_ALARM_FAULT: begin
          alarmSet[j] = trig[j];
          faultSet[j] = trig[j] & delayDone_q[j];
        end
        default: begin
          alarmSet[j] = 1'b0;
          faultSet[j] = trig[j] & delayDone_q[j];
        end
      endcase
      // Reset only counts once the trigger is gone
      faultClr[j] = (faultReset & ~trig[j]) |
                    (mode_q[j] == `MODE_OFF);
    end
  end

  //--------------------------------------------------------------
  // Alarm and fault outputs
  //--------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmFlag    <= 3'h0;
      faultRequest <= 3'h0;
    end else begin
      alarmFlag    <= alarmSet;
      // Set wins over a clear in the same cycle
      faultRequest <= faultSet | (faultRequest & ~faultClr);
    end
  end

  //--------------------------------------------------------------
  // Shutdown request
  //--------------------------------------------------------------
  // Any latched channel stops the inverter
  assign faultShutdown = |faultRequest;

endmodule

/* File: hdl/process_fault_monitor_defines.vh */
// Constants for the process fault monitor
`ifndef PROCESS_FAULT_MONITOR_DEFINES_VH
`define PROCESS_FAULT_MONITOR_DEFINES_VH

// Monitor mode codes
`define MODE_OFF        3'h0
`define MODE_NO_ALWAYS  3'h1
`define MODE_NO_READY   3'h2
`define MODE_NO_RUN     3'h3
`define MODE_NC_ALWAYS  3'h4
`define MODE_NC_READY   3'h5
`define MODE_NC_RUN     3'h6

// Response codes
`define RESP_ALARM       2'h1
`define RESP_ALARM_FAULT 2'h2
`define RESP_FAULT       2'h3

// Reset values
`define MODE_RESET 3'h0
`define RESP_RESET 2'h3
`define DELAY_RESET 10'h0

// Limits in seconds
`define REACT_MAX_S 10'h12c
`define START_MAX_S 10'h258

// Clock and tick
`define CLK_HZ          125000000
`define TICK_PERIOD_MS  1
`define TICK_CYCLES     (`CLK_HZ / 1000 * `TICK_PERIOD_MS)
`define TICKS_PER_S     1000

`endif

/* File: verif/process_contacts.sv */
// Model of the external process contacts
`timescale 1ns/100ps
module process_contacts (
  input  logic [2:0] closeReq,
  output logic [2:0] faultIn
);
  // Contacts settle away from the clock edge
  assign #3 faultIn = closeReq;
endmodule

/* File: verif/process_fault_monitor_checker.sv */
// Port checks for the process fault monitor
`timescale 1ns/100ps
module process_fault_monitor_checker (
  input logic       clk,
  input logic       rst_n,
  input logic [2:0] faultIn,
  input logic       stateRun,
  input logic       faultReset,
  input logic       cfgLoad,
  input logic [2:0] ch1MonitorMode,
  input logic [1:0] ch1ResponseSelect,
  input logic [9:0] ch1ReactionDelay,
  input logic [2:0] alarmFlag,
  input logic [2:0] faultRequest,
  input logic       faultShutdown
);
  logic [2:0] mode_q;
  logic [1:0] resp_q;
  logic       zero_q, sync1_q, sync2_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Channel one settings and synced input
  // ----------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {mode_q, resp_q, zero_q, sync1_q, sync2_q} <= 8'h1c;
    end else begin
      {sync1_q, sync2_q} <= {faultIn[0], sync1_q};
      if (cfgLoad) begin
        mode_q <= ch1MonitorMode > 3'h6 ? 3'h0 : ch1MonitorMode;
        resp_q <= ch1ResponseSelect == 2'h0 ? 2'h3 : ch1ResponseSelect;
        zero_q <= ch1ReactionDelay == 10'h0;
      end
    end
  end
  sequence s_run_off;
    !stateRun [*3];
  endsequence
  sequence s_mode_off;
    (mode_q == 3'h0) [*3];
  endsequence
  a_shutdown_or: assert property (faultShutdown == |faultRequest)
    else $error("shutdown differs from requests");
  a_reset_clean: assert property ($rose(rst_n) |-> !faultRequest && !alarmFlag)
    else $error("outputs set after reset");
  a_fault_hold: assert property ($fell(faultRequest[0]) |->
    $past(faultReset) || $past(faultReset, 2) || $past(cfgLoad)
    || $past(cfgLoad, 2)) else $error("fault dropped without reset");
  a_mode_off: assert property (s_mode_off |-> !faultRequest[0])
    else $error("fault while mode off");
  a_alarm_only: assert property (resp_q == 2'h1 && !faultRequest[0] |=>
    !faultRequest[0]) else $error("fault from alarm response");
  a_alarm_early: assert property (mode_q == 3'h1 && resp_q == 2'h2 &&
    $rose(sync2_q) |-> ##[0:2] alarmFlag[0]) else $error("alarm late");
  a_alarm_drop: assert property (mode_q == 3'h1 && resp_q == 2'h2 &&
    $fell(sync2_q) |-> ##[0:2] !alarmFlag[0]) else $error("alarm stuck");
  a_fault_fast: assert property (mode_q == 3'h4 && resp_q == 2'h3 &&
    zero_q && $fell(sync2_q) |-> ##[0:3] faultRequest[0])
    else $error("fault late");
  a_run_only: assert property (s_run_off ##0 (mode_q == 3'h3 &&
    !faultRequest[0]) |=> !faultRequest[0]) else $error("fault outside run");
endmodule
bind process_fault_monitor process_fault_monitor_checker u_chk (.*);

/* File: verif/process_fault_monitor_tb.sv */
// Testbench for the process fault monitor
`timescale 1ns/100ps
module process_fault_monitor_tb;
  logic       clk = 0, rst_n = 0, stateReady = 0, stateRun = 0;
  logic       startCmd = 0, faultReset = 0, cfgLoad = 0;
  logic [2:0] ch1MonitorMode = 0, closeReq = 0, idle;
  logic [1:0] ch1ResponseSelect = 3;
  logic [9:0] ch1StartBlankTime = 0, ch1ReactionDelay = 0;
  wire  [2:0] faultIn, alarmFlag, faultRequest;
  wire        faultShutdown;
  int         err_count = 0, samples_checked = 0;
  process_contacts u_contacts (.closeReq(closeReq), .faultIn(faultIn));
  process_fault_monitor #(.TICK_CYCLES(4), .TICKS_PER_S(4)) u_dut (.*,
    .ch2MonitorMode(ch1MonitorMode), .ch3MonitorMode(ch1MonitorMode),
    .ch2ResponseSelect(ch1ResponseSelect),
    .ch3ResponseSelect(ch1ResponseSelect),
    .ch2StartBlankTime(ch1StartBlankTime),
    .ch3StartBlankTime(ch1StartBlankTime),
    .ch2ReactionDelay(ch1ReactionDelay), .ch3ReactionDelay(ch1ReactionDelay));
  initial forever #4 clk = ~clk;
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic cfg(input logic [2:0] m, input logic [1:0] r,
                     input logic [9:0] b, input logic [9:0] d);
    @(negedge clk);
    {ch1MonitorMode, ch1ResponseSelect} = {m, r};
    {ch1StartBlankTime, ch1ReactionDelay} = {b, d};
    cfgLoad = 1;
    cyc(1);
    cfgLoad = 0;
  endtask
  task automatic clr(input logic [2:0] v);
    @(negedge clk) closeReq = v;
    cyc(4);
    faultReset = 1;
    cyc(2);
    faultReset = 0;
  endtask
  task automatic chk(input logic a, input logic f);
    samples_checked++;
    if (alarmFlag !== {3{a}} || faultRequest !== {3{f}} ||
        faultShutdown !== f) begin
      err_count++;
      $display("[ERR] %0t got %b %b", $time, alarmFlag, faultRequest);
    end
  endtask
  task automatic start;
    closeReq = 3'h7;
    startCmd = 1;
    cyc(1);
    startCmd = 0;
    cyc(6);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(5000);
    err_count++;
    give_verdict;
  end
  initial begin
    cyc(5);
    rst_n = 1;
    chk(0, 0);
    closeReq = 3'h7;
    cyc(10);
    chk(0, 0);
    for (int m = 1; m < 7; m++) begin
      for (int s = 0; s < 3; s++) begin
        idle = m < 4 ? 3'h0 : 3'h7;
        cfg(3'(m), 2'h3, 10'h0, 10'h0);
        clr(idle);
        {stateRun, stateReady} = {s == 2, s == 1};
        closeReq = ~idle;
        cyc(8);
        chk(0, m % 3 == 1 || m % 3 == 2 && s > 0 || s == 2);
      end
    end
    cfg(3'h2, 2'h1, 10'h0, 10'h2);
    clr(3'h0);
    closeReq = 3'h7;
    cyc(8);
    chk(0, 0);
    cyc(40);
    chk(1, 0);
    cfg(3'h1, 2'h2, 10'h0, 10'h2);
    clr(3'h0);
    closeReq = 3'h7;
    cyc(4);
    chk(1, 0);
    cyc(40);
    chk(1, 1);
    faultReset = 1;
    cyc(2);
    chk(1, 1);
    faultReset = 0;
    closeReq = 3'h0;
    cyc(4);
    chk(0, 1);
    clr(3'h0);
    chk(0, 0);
    cfg(3'h1, 2'h3, 10'h0, 10'h2);
    closeReq = 3'h7;
    cyc(16);
    closeReq = 3'h0;
    cyc(50);
    chk(0, 0);
    cfg(3'h3, 2'h3, 10'h2, 10'h0);
    start;
    chk(0, 0);
    cyc(30);
    chk(0, 1);
    clr(3'h0);
    cfg(3'h1, 2'h3, 10'h1, 10'h0);
    start;
    chk(0, 1);
    give_verdict;
  end
endmodule
